// ==== hdl/lmns_baud_detect.sv ====
// Fieldbus transfer rate detection from the shortest pulse on the line.
// Assumes rxd is already synchronised to clock.
`timescale 1ns/10ps
module lmns_baud_detect #(
  parameter int EDGE_WIN = 64,
  parameter int RUN_W    = 12
) (
  // System
  input  wire logic                          clock,
  input  wire logic                          resetn,
  // Line and result
  input  wire logic                          rxd,
  output logic      [lmns_pkg::BAUD_IDX_W-1:0] rate_idx,
  output logic                               rate_valid
);
  import lmns_pkg::*;

  logic             prev;
  logic [RUN_W-1:0] run;
  logic [RUN_W-1:0] min_run;
  logic [RUN_W-1:0] next_min;
  logic [7:0]       edges;
  logic             edge_seen;

  // Nearest rate: pick the fastest rate whose midpoint still exceeds the run
  function automatic logic [BAUD_IDX_W-1:0] classify(input logic [RUN_W-1:0] r);
    logic [BAUD_IDX_W-1:0] idx;
    int unsigned           mid;
    idx = '0;
    for (int i = 1; i < BAUD_N; i++) begin
      mid = (CLK_HZ / BAUD_HZ[i-1] + CLK_HZ / BAUD_HZ[i]) / 2;
      if (32'(r) < mid) begin
        idx = BAUD_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  assign edge_seen = (rxd != prev);
  assign next_min  = (run < min_run) ? run : min_run;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prev       <= 1'b1;
      run        <= '0;
      min_run    <= '1;
      edges      <= '0;
      rate_idx   <= '0;
      rate_valid <= 1'b0;
    end else begin
      prev <= rxd;
      if (edge_seen) begin
        run <= RUN_W'(1);
        if (edges == 8'(EDGE_WIN - 1)) begin
          // Window closes: classify and start measuring afresh
          rate_idx   <= classify(next_min);
          rate_valid <= 1'b1;
          min_run    <= '1;
          edges      <= '0;
        end else begin
          min_run <= next_min;
          edges   <= edges + 8'h01;
        end
      end else if (run != '1) begin
        run <= run + RUN_W'(1);
      end
    end
  end

  rate_range_a: assert property (@(posedge clock) disable iff (!resetn)
    rate_valid |-> rate_idx < BAUD_IDX_W'(BAUD_N))
    else $error("rate index out of range");
endmodule // lmns_baud_detect

// ==== hdl/lmns_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so pointers wrap naturally.
`timescale 1ns/10ps
module lmns_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // System
  input wire logic clock,
  input wire logic resetn,
  // Streams
  lmns_stream_if.snk in_s,
  lmns_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             nonempty;
  logic             push;
  logic             pop;

  assign push        = in_s.valid && in_s.ready;
  assign pop         = nonempty && out_s.ready;
  assign in_s.ready  = (count != CW'(DEPTH));
  assign out_s.valid = nonempty;
  assign out_s.data  = mem[rd_ptr];
  assign next_count  = count + CW'(push) - CW'(pop);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      nonempty <= 1'b0;
    end else begin
      wr_ptr   <= wr_ptr + PW'(push);
      rd_ptr   <= rd_ptr + PW'(pop);
      count    <= next_count;
      nonempty <= (next_count != '0);
    end
  end
endmodule // lmns_fifo

// ==== hdl/lmns_pkg.sv ====
// Shared constants for the link master node supervision block.
// Assumes a single 25 MHz system clock and a synchronous active-low reset.
package lmns_pkg;
  // ==========================================================================
  // Link and node limits
  localparam int              NODE_MAX    = 14;
  localparam int              ADDR_W      = 4;
  localparam int              SLOT_W      = 5;
  localparam logic [3:0]      FIRST_ADDR  = 4'h1;
  localparam int              PD_MAX_BITS = 128;
  localparam int              PD_LEN_W    = 8;
  // Consecutive unanswered polls before a node counts as lost
  localparam int              MISS_W      = 2;
  localparam logic [1:0]      MISS_LAST   = 2'h2;
  // ==========================================================================
  // Station address switches
  localparam logic [3:0]      DIGIT_MAX       = 4'h9;
  localparam logic [6:0]      TENS_WEIGHT     = 7'h0A;
  localparam logic [6:0]      STATION_DEFAULT = 7'h03;
  localparam logic [6:0]      STATION_MAX     = 7'h63;
  localparam logic [2:0]      SW_SETTLE       = 3'h4;
  // ==========================================================================
  // Fieldbus rate detection
  localparam int              CLK_HZ      = 25_000_000;
  localparam int              BAUD_N      = 9;
  localparam int              BAUD_IDX_W  = 4;
  localparam int              BAUD_HZ [BAUD_N] = '{9600, 19200, 93750, 187500, 500000,
                                                   1500000, 3000000, 6000000, 12000000};
endpackage

// ==== hdl/lmns_stream_if.sv ====
// Valid/ready word stream between the supervisor and its FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface lmns_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/lmns_top.sv ====
// Supervisor of slave nodes for the link master, with station address
// capture, fieldbus rate detection and a data FIFO toward the upstream side.
// Assumes a link engine that performs each poll and answers with poll_done.
//
// Contract
// - Master keeps polling every configured node throughout operation; polling pauses while the upstream FIFO is full.
// - Link fault indicator goes off once all configured nodes communicate.
// - Silent node lights its own indicator; master reports fault upstream.
// - On node loss master clears its live bit and lights own indicator.
// - Data exchange with remaining nodes continues while one node is missing.
// - Returning node clears fault; master clears indicator when config complete.
// - Configured input and output data length never exceeds 128 bits.
// - Station address is tens*10+units, range 0 to 99, default 3.
// - Address switches sampled once after reset, later changes ignored.
// - Fieldbus transfer rate detected automatically, 9.6 to 12000 kBaud.
// - Node address 1 maps to slot 0, each next address to next slot.
// - Combined node takes two slots, shifting every later slot by one.
// - Configuration mismatching present nodes keeps station not accepted; code checks missing nodes and the one probe address only.
// - At most fourteen slave nodes, each with its own address.
`timescale 1ns/10ps
module lmns_top #(
  parameter int PAYLOAD_W  = 16,
  parameter int FIFO_DEPTH = 8,
  parameter int EDGE_WIN   = 64
) (
  // System
  input  wire logic                              clock,
  input  wire logic                              resetn,
  // Station address switches and fieldbus line
  input  wire logic [3:0]                        station_address_tens_switch,
  input  wire logic [3:0]                        station_address_units_switch,
  input  wire logic                              fb_rxd,
  // Configuration from the fieldbus master
  input  wire logic                              cfg_load,
  input  wire logic [lmns_pkg::ADDR_W-1:0]       cfg_node_count,
  input  wire logic [lmns_pkg::NODE_MAX-1:0]     cfg_combi_mask,
  input  wire logic [lmns_pkg::PD_LEN_W-1:0]     cfg_in_bits,
  input  wire logic [lmns_pkg::PD_LEN_W-1:0]     cfg_out_bits,
  // Link engine
  output logic                                   poll_req,
  output logic      [lmns_pkg::ADDR_W-1:0]       poll_addr,
  input  wire logic                              poll_done,
  input  wire logic                              poll_answered,
  input  wire logic                              poll_data_valid,
  input  wire logic                              poll_second,
  input  wire logic [PAYLOAD_W-1:0]              poll_data,
  // Upstream data stream: {slot, payload}
  output logic                                   up_valid,
  input  wire logic                              up_ready,
  output logic      [lmns_pkg::SLOT_W+PAYLOAD_W-1:0] up_data,
  // Status
  output logic      [lmns_pkg::NODE_MAX-1:0]     live_bits,
  output logic      [lmns_pkg::ADDR_W-1:0]       live_count,
  output logic                                   link_fault_led,
  output logic                                   fault_report,
  output logic                                   fault_event,
  output logic                                   station_accepted,
  output logic                                   cfg_error,
  output logic      [6:0]                        station_address,
  output logic                                   station_address_valid,
  output logic      [lmns_pkg::BAUD_IDX_W-1:0]   baud_idx,
  output logic                                   baud_valid
);
  import lmns_pkg::*;

  localparam int WORD_W = SLOT_W + PAYLOAD_W;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} lmns_state_e;

  // ==========================================================================
  // Helpers
  function automatic logic [NODE_MAX-1:0] low_mask(input logic [ADDR_W-1:0] n);
    logic [NODE_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < NODE_MAX; i++) begin
      m[i] = (ADDR_W'(i) < n);
    end
    return m;
  endfunction

  function automatic logic [ADDR_W-1:0] pop_count(input logic [NODE_MAX-1:0] v);
    logic [ADDR_W-1:0] c;
    c = '0;
    for (int i = 0; i < NODE_MAX; i++) begin
      c = c + ADDR_W'(v[i]);
    end
    return c;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] tens_s1;
  logic [3:0] tens_s2;
  logic [3:0] units_s1;
  logic [3:0] units_s2;
  logic       rxd_s1;
  logic       rxd_s2;

  always_ff @(posedge clock) begin
    tens_s1  <= station_address_tens_switch;
    tens_s2  <= tens_s1;
    units_s1 <= station_address_units_switch;
    units_s2 <= units_s1;
    rxd_s1   <= fb_rxd;
    rxd_s2   <= rxd_s1;
  end

  // ==========================================================================
  // Station address, caught once after reset release
  logic [2:0] settle;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      settle                <= '0;
      station_address       <= STATION_DEFAULT;
      station_address_valid <= 1'b0;
    end else if (!station_address_valid) begin
      if (settle != SW_SETTLE) begin
        settle <= settle + 3'h1;
      end else begin
        // An illegal digit falls back to the factory address
        if (tens_s2 > DIGIT_MAX || units_s2 > DIGIT_MAX) begin
          station_address <= STATION_DEFAULT;
        end else begin
          station_address <= 7'(tens_s2) * TENS_WEIGHT + 7'(units_s2);
        end
        station_address_valid <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Fieldbus rate detection
  lmns_baud_detect #(
    .EDGE_WIN (EDGE_WIN)
  ) u_baud (
    .clock      (clock),
    .resetn     (resetn),
    .rxd        (rxd_s2),
    .rate_idx   (baud_idx),
    .rate_valid (baud_valid)
  );

  // ==========================================================================
  // Configuration
  logic                cfg_ok;
  logic [ADDR_W-1:0]   node_count;
  logic [NODE_MAX-1:0] cfg_mask;
  logic [NODE_MAX-1:0] combi_mask;
  logic                cfg_bad;

  assign cfg_bad = (cfg_in_bits > PD_LEN_W'(PD_MAX_BITS))
                || (cfg_out_bits > PD_LEN_W'(PD_MAX_BITS))
                || (cfg_node_count > ADDR_W'(NODE_MAX))
                || (cfg_node_count == '0);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_ok     <= 1'b0;
      cfg_error  <= 1'b0;
      node_count <= '0;
      cfg_mask   <= '0;
      combi_mask <= '0;
    end else if (cfg_load) begin
      // An oversized or overfull configuration is refused outright
      cfg_ok     <= !cfg_bad;
      cfg_error  <= cfg_bad;
      node_count <= cfg_bad ? '0 : cfg_node_count;
      cfg_mask   <= cfg_bad ? '0 : low_mask(cfg_node_count);
      combi_mask <= cfg_bad ? '0 : cfg_combi_mask & low_mask(cfg_node_count);
    end
  end

  // ==========================================================================
  // Poll sequencer: addresses 1..count, plus one probe above the last unless count is fourteen
  lmns_state_e       state;
  logic [ADDR_W-1:0] last_addr;
  logic              done_ok;
  logic              node_hit;
  logic              probe_hit;
  logic [ADDR_W-1:0] hit_idx;
  logic              room;

  assign last_addr = (node_count == ADDR_W'(NODE_MAX)) ? node_count : node_count + FIRST_ADDR;
  assign done_ok   = (state == ST_WAIT) && poll_done;
  assign node_hit  = done_ok && cfg_ok && (poll_addr <= node_count);
  assign probe_hit = done_ok && cfg_ok && (poll_addr > node_count);
  assign hit_idx   = poll_addr - FIRST_ADDR;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      poll_req  <= 1'b0;
      poll_addr <= FIRST_ADDR;
    end else begin
      poll_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          poll_addr <= FIRST_ADDR;
          if (cfg_ok) begin
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          // Wait for FIFO room so an answer is never dropped
          if (!cfg_ok) begin
            state <= ST_IDLE;
          end else if (room) begin
            poll_req <= 1'b1;
            state    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (poll_done) begin
            // A silent node does not stop the round
            state     <= ST_ISSUE;
            poll_addr <= (poll_addr >= last_addr) ? FIRST_ADDR : poll_addr + FIRST_ADDR;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Per-node live bit and miss counter
  logic [NODE_MAX-1:0] lost_vec;
  logic                lost_now;

  generate
    for (genvar g = 0; g < NODE_MAX; g++) begin : g_node
      logic              live_r;
      logic [MISS_W-1:0] miss;
      logic              mine;

      assign mine         = node_hit && (hit_idx == ADDR_W'(g));
      assign lost_vec[g]  = mine && !poll_answered && live_r && (miss == MISS_LAST);
      assign live_bits[g] = live_r;

      always_ff @(posedge clock) begin
        if (!resetn) begin
          live_r <= 1'b0;
          miss   <= '0;
        end else if (mine) begin
          if (poll_answered) begin
            live_r <= 1'b1;
            miss   <= '0;
          end else if (miss == MISS_LAST) begin
            live_r <= 1'b0;
          end else begin
            miss <= miss + MISS_W'(1);
          end
        end
      end
    end
  endgenerate

  assign lost_now = |lost_vec;

  // ==========================================================================
  // Fault indication and acceptance
  logic complete;
  logic extra_seen;

  // A node being lost in this cycle already counts as missing, so the
  // indicator lights together with the loss event, not a cycle later
  assign complete = cfg_ok && (((live_bits & ~lost_vec) & cfg_mask) == cfg_mask);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      extra_seen <= 1'b0;
    end else if (cfg_load) begin
      extra_seen <= 1'b0;
    end else if (probe_hit) begin
      extra_seen <= poll_answered;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      link_fault_led   <= 1'b1;
      fault_report     <= 1'b0;
      fault_event      <= 1'b0;
      station_accepted <= 1'b0;
      live_count       <= '0;
    end else begin
      link_fault_led   <= !complete;
      fault_report     <= cfg_ok && !complete;
      fault_event      <= lost_now;
      station_accepted <= complete && !extra_seen;
      // Duplicate addresses are not seen here; the count lets the controller check
      live_count       <= pop_count(live_bits);
    end
  end

  // ==========================================================================
  // Data path into the FIFO, tagged with the module slot
  logic [SLOT_W-1:0] slot;

  assign slot = SLOT_W'(hit_idx)
              + SLOT_W'(pop_count(combi_mask & low_mask(hit_idx)))
              + SLOT_W'(poll_second && combi_mask[hit_idx]);

  lmns_stream_if #(.WIDTH(WORD_W)) wr_s ();
  lmns_stream_if #(.WIDTH(WORD_W)) rd_s ();

  assign wr_s.valid = node_hit && poll_answered && poll_data_valid;
  assign wr_s.data  = {slot, poll_data};
  assign room       = wr_s.ready;
  assign rd_s.ready = up_ready;
  assign up_valid   = rd_s.valid;
  assign up_data    = rd_s.data;

  lmns_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock  (clock),
    .resetn (resetn),
    .in_s   (wr_s),
    .out_s  (rd_s)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  fault_led_off_a: assert property (complete |=> !link_fault_led)
    else $error("fault indicator on with configuration complete");
  node_loss_a: assert property (lost_now |=> fault_event && link_fault_led)
    else $error("node loss not reported");
  live_clear_a: assert property (node_hit && !poll_answered && lost_vec != '0
    |=> !live_bits[$past(hit_idx)])
    else $error("lost node still live");
  poll_range_a: assert property (poll_req |-> poll_addr >= FIRST_ADDR
    && poll_addr <= last_addr)
    else $error("poll address out of range");
  poll_advance_a: assert property (done_ok ##1 (cfg_ok && room) |=> poll_req)
    else $error("polling stalled after silent node");
  cfg_limit_a: assert property (cfg_load && cfg_in_bits > PD_LEN_W'(PD_MAX_BITS)
    |=> cfg_error && !cfg_ok)
    else $error("oversized configuration accepted");
  addr_range_a: assert property (station_address_valid |-> station_address <= STATION_MAX)
    else $error("station address above range");
  addr_frozen_a: assert property (station_address_valid |=> $stable(station_address))
    else $error("station address changed in operation");
  accept_match_a: assert property (station_accepted |-> $past(complete)
    && !$past(extra_seen))
    else $error("station accepted on mismatched nodes");
  live_set_a: assert property (node_hit && poll_answered
    |=> live_bits[$past(hit_idx)])
    else $error("answering node not live");
  slot_first_a: assert property (wr_s.valid && poll_addr == FIRST_ADDR && !poll_second
    |-> slot == '0)
    else $error("first node not in slot zero");
endmodule // lmns_top

// ==== verification/link_master_node_supervision_tb_top.sv ====
// ============================================================================
// Self-checking bench for lmns_top with a behavioural node model.
// Assumes combined nodes are those set in combi; payload carries {addr, second}.
`timescale 1ns/10ps
module link_master_node_supervision_tb_top;
  import lmns_pkg::*;
  logic clock, resetn, fb_rxd, cfg_load, poll_req, poll_done, poll_answered;
  logic poll_data_valid, poll_second, up_valid, up_ready, fault_report, fault_event;
  logic link_fault_led, station_accepted, cfg_error, station_address_valid, baud_valid, slow;
  logic [3:0]  tens, units, cfg_node_count, poll_addr, live_count, baud_idx;
  logic [13:0] live_bits, present, combi;
  logic [7:0]  cfg_in_bits, cfg_out_bits;
  logic [15:0] poll_data;
  logic [20:0] up_data;
  logic [6:0]  station_address;
  int error_cnt, checks_done, cycles, polls;
  int words [16];
  lmns_top #(.PAYLOAD_W(16), .FIFO_DEPTH(8), .EDGE_WIN(8)) u_dut (
    .clock(clock), .resetn(resetn), .station_address_tens_switch(tens),
    .station_address_units_switch(units), .fb_rxd(fb_rxd), .cfg_load(cfg_load),
    .cfg_node_count(cfg_node_count), .cfg_combi_mask(combi), .cfg_in_bits(cfg_in_bits),
    .cfg_out_bits(cfg_out_bits), .poll_req(poll_req), .poll_addr(poll_addr),
    .poll_done(poll_done), .poll_answered(poll_answered), .poll_data_valid(poll_data_valid),
    .poll_second(poll_second), .poll_data(poll_data), .up_valid(up_valid),
    .up_ready(up_ready), .up_data(up_data), .live_bits(live_bits), .live_count(live_count),
    .link_fault_led(link_fault_led), .fault_report(fault_report), .fault_event(fault_event),
    .station_accepted(station_accepted), .cfg_error(cfg_error),
    .station_address(station_address), .station_address_valid(station_address_valid),
    .baud_idx(baud_idx), .baud_valid(baud_valid));
  lmns_node_model u_nodes (
    .clock(clock), .resetn(resetn), .present(present), .slow(slow), .poll_req(poll_req),
    .poll_addr(poll_addr), .poll_done(poll_done), .poll_answered(poll_answered),
    .poll_data_valid(poll_data_valid), .poll_second(poll_second), .poll_data(poll_data));
  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic load(input logic [3:0] n, input logic [7:0] ib, input logic [7:0] ob);
    @(negedge clock);
    {cfg_node_count, cfg_in_bits, cfg_out_bits, cfg_load} = {n, ib, ob, 1'b1};
    @(negedge clock);
    cfg_load = 1'b0;
    @(negedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Monitors look just past the falling edge, where outputs and stimulus are settled
  always @(negedge clock) begin
    #1;
    cycles++;
    if (poll_req === 1'b1)
      polls++;
    if (cycles == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Word taken at the next rising edge: slot shifts once per combined node below it
  always @(negedge clock) begin
    #1;
    if (up_valid === 1'b1 && up_ready === 1'b1) begin
      check(up_data[20:16], up_data[15:12] - 1 + (up_data[0] && combi[up_data[15:12] - 1])
            + $countones(combi & ((14'h0001 << (up_data[15:12] - 1)) - 14'h0001)),
            "slot");
      words[up_data[15:12]]++;
    end
  end
  // ==========================================================================
  // Scenarios
  task automatic t_switch;
    check(station_address_valid, 1, "addr valid");
    check(station_address, 7'h2A, "addr value");
    {tens, units} = 8'h99;
    repeat (20) @(negedge clock);
    check(station_address, 7'h2A, "addr held");
  endtask
  task automatic t_refuse;
    logic [3:0] n [4] = '{4'h0, 4'hF, 4'h3, 4'h3};
    logic [7:0] ib [4] = '{8'h08, 8'h08, 8'h81, 8'h08};
    logic [7:0] ob [4] = '{8'h08, 8'h08, 8'h08, 8'h81};
    for (int i = 0; i < 4; i++) begin
      load(n[i], ib[i], ob[i]);
      check(cfg_error, 1, "refused cfg");
    end
    polls = 0;
    repeat (30) @(negedge clock);
    check(polls, 0, "no poll");
    check(link_fault_led, 1, "led lit");
  endtask
  task automatic t_run;
    load(4'h3, 8'h80, 8'h80);
    check(cfg_error, 0, "max length");
    for (int i = 0; i < 400 && live_bits !== 14'h0007; i++) @(negedge clock);
    repeat (3) @(negedge clock);
    check(live_bits, 14'h0007, "all live");
    check(link_fault_led, 0, "led off");
    check({fault_report, station_accepted}, 2'b01, "accepted");
    check(live_count, 3, "live count");
  endtask
  task automatic t_loss;
    slow = 1'b1;
    present = 14'h0005;
    for (int i = 0; i < 600 && fault_event !== 1'b1; i++) @(negedge clock);
    check(fault_event, 1, "loss event");
    check(live_bits, 14'h0005, "live cleared");
    check({link_fault_led, fault_report, station_accepted}, 3'b110, "fault shown");
    words = '{default: 0};
    repeat (300) @(negedge clock);
    check(words[1] > 0 && words[3] > 0, 1, "others served");
    check(live_count, 2, "live count");
    present = 14'h0007;
    for (int i = 0; i < 400 && live_bits !== 14'h0007; i++) @(negedge clock);
    repeat (3) @(negedge clock);
    check({link_fault_led, fault_report}, 2'b00, "fault cleared");
    slow = 1'b0;
  endtask
  task automatic t_probe;
    present = 14'h000F;
    repeat (200) @(negedge clock);
    check(station_accepted, 0, "extra node");
    present = 14'h0007;
    repeat (200) @(negedge clock);
    check(station_accepted, 1, "match again");
    // Drop the configuration so the stream drains, then combine nodes 1 and 3
    load(4'h0, 8'h10, 8'h10);
    repeat (20) @(negedge clock);
    combi = 14'h0005;
    load(4'h3, 8'h10, 8'h10);
    repeat (100) @(negedge clock);
    check(station_accepted, 1, "combi reload");
  endtask
  task automatic t_fifo;
    up_ready = 1'b0;
    repeat (300) @(negedge clock);
    polls = 0;
    repeat (100) @(negedge clock);
    check(polls, 0, "stall when full");
    check(up_valid, 1, "word held");
    up_ready = 1'b1;
    repeat (100) @(negedge clock);
    check(polls > 0, 1, "polling resumes");
  endtask
  task automatic t_baud;
    // 500 kBaud is 50 clock cycles a bit
    repeat (24) begin
      repeat (50) @(negedge clock);
      fb_rxd = ~fb_rxd;
    end
    repeat (5) @(negedge clock);
    check({baud_valid, baud_idx}, 5'h14, "rate");
  endtask
  task automatic t_default;
    // An illegal tens digit at restart falls back to the factory address
    tens = 4'hA;
    resetn = 1'b0;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (10) @(negedge clock);
    check({station_address_valid, station_address}, 8'h83, "bad digit");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {resetn, fb_rxd, cfg_load, up_ready, slow} = 5'b01010;
    {tens, units, cfg_node_count, cfg_in_bits, cfg_out_bits} = {8'h42, 4'h0, 16'h0000};
    {present, combi} = {14'h0007, 14'h0002};
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (10) @(negedge clock);
    t_switch();
    t_refuse();
    t_run();
    t_loss();
    t_probe();
    t_fifo();
    t_baud();
    t_default();
    report_and_stop();
  end
endmodule // link_master_node_supervision_tb_top

// ==== verification/lmns_node_model.sv ====
// ============================================================================
// Behavioural link engine with its slave nodes, answering each poll.
// Assumes poll_req is a one-cycle pulse and poll_addr holds until poll_done.
`timescale 1ns/10ps
module lmns_node_model (
  // System
  input  wire logic        clock,
  input  wire logic        resetn,
  // Scenario control
  input  wire logic [13:0] present,
  input  wire logic        slow,
  // Poll interface
  input  wire logic        poll_req,
  input  wire logic [3:0]  poll_addr,
  output logic             poll_done,
  output logic             poll_answered,
  output logic             poll_data_valid,
  output logic             poll_second,
  output logic [15:0]      poll_data
);
  logic       busy;
  logic [2:0] cnt;
  logic       flip;
  logic       ans;
  initial begin
    {busy, cnt, flip, poll_done, poll_answered, poll_data_valid, poll_second} = '0;
    poll_data = 16'h0000;
  end
  // Qualifiers toggle outside poll_done so a stale value can never pass
  always @(negedge clock) begin
    if (!resetn) begin
      busy = 1'b0;
      poll_done <= 1'b0;
    end else if (busy && cnt == 3'h0) begin
      busy = 1'b0;
      ans = (poll_addr != 4'h0) && (poll_addr <= 4'hE) && present[poll_addr - 4'h1];
      poll_done <= 1'b1;
      poll_answered <= ans;
      poll_data_valid <= ans;
      poll_second <= flip;
      poll_data <= {poll_addr, 11'h000, flip};
      if (ans)
        flip = ~flip;
    end else begin
      poll_done <= 1'b0;
      poll_answered <= ~poll_answered;
      poll_data_valid <= ~poll_data_valid;
      poll_second <= ~poll_second;
      poll_data <= ~poll_data;
      if (busy)
        cnt = cnt - 3'h1;
      else if (poll_req === 1'b1) begin
        busy = 1'b1;
        cnt = slow ? 3'h4 : 3'h0;
      end
    end
  end
endmodule // lmns_node_model
